// file: src/cxr_output_port.sv
// Output and error stage of the biphase receiver with its register slave.
//
// Our own choices: register access over Avalon-MM and the register addresses.
`include "cxr_consts.svh"

module cxr_output_port
  import cxr_pkg::*;
#(
  parameter int RX_DIV = `CXR_RX_DIV_DEF, // Core cycles per receiver period.
  parameter int TW     = 16
) (
  input  wire logic         I_CORE_CLK,        // Core clock, 250 MHz.
  input  wire logic         I_SYS_RST,         // Synchronous reset.
  input  wire cxr_line_ev_t I_LINE_EV,         // Demodulator events.
  input  wire logic         I_RX_DISABLE,      // Line inputs disabled.
  input  wire logic         I_OUT_SEL,         // 1 data, 0 error codes.
  input  wire logic         I_OUT_EN,          // Drive the data bus.
  input  wire logic         I_REG_READ_N,      // Read strobe, active low.
  output logic [9:0]        O_DATA,            // Parallel data bus.
  output logic [9:0]        O_DATA_OE,         // Bus output enables.
  output logic              O_RX_ACTIVE,       // Message active.
  output logic              O_DATA_AVAIL,      // Held word ready.
  output logic              O_ERROR,           // Error detected.
  input  wire logic [3:0]   I_AVS_ADDRESS,     // Byte address.
  input  wire logic         I_AVS_READ,        // Read request.
  input  wire logic         I_AVS_WRITE,       // Write request.
  input  wire logic [31:0]  I_AVS_WRITEDATA,   // Write data.
  input  wire logic [3:0]   I_AVS_BYTEENABLE,  // Byte lanes.
  output logic [31:0]       O_AVS_READDATA,    // Read data.
  output logic              O_AVS_WAITREQUEST  // Stall.
);

  ////////////////////////////////////////////////////////////////////////////
  // Timing figures in core cycles; half periods keep the .5 until the divide by 2, which truncates it.

  localparam int RISE_CYC =
    (`CXR_RISE_HALF_T * RX_DIV) / 2 + `CXR_NS2CYC(`CXR_RISE_EXTRA_NS);
  localparam int FIRST_CYC = `CXR_FIRST_T * RX_DIV;
  localparam int FALL_CYC  =
    (`CXR_FALL_HALF_T * RX_DIV) / 2 + `CXR_NS2CYC(`CXR_FALL_EXTRA_NS);

  function automatic logic [9:0] err_word(input cxr_err_flags_t f);
    cxr_err_flags_t g;
    g = f;
    g.transmit_check_flag_bit = f.parity_flag_bit |
                                f.bad_ending_flag_bit |
                                f.lost_transition_flag_bit;
    err_word = {1'b0, g, 2'b00};
  endfunction

  function automatic logic lane_hit(input logic [3:0] addr,
                                    input logic [3:0] off);
    lane_hit = (addr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register bus: one wait state, then the access completes.

  logic        wait_q;
  logic [31:0] ctrl_q;
  logic        bus_req;
  logic        bus_go;

  assign bus_req = I_AVS_READ | I_AVS_WRITE;
  assign bus_go  = bus_req & ~wait_q;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(bus_req & wait_q);
    end
  end

  assign O_AVS_WAITREQUEST = wait_q;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      ctrl_q <= `CXR_CTRL_RST;
    end else if (bus_go && I_AVS_WRITE &&
                 lane_hit(I_AVS_ADDRESS, `CXR_REG_CTRL) &&
                 I_AVS_BYTEENABLE[0]) begin
      ctrl_q <= {31'h0, I_AVS_WRITEDATA[`CXR_CTRL_DIS_BIT]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line events, gated by the disable inputs.

  cxr_state_t     state_q;
  cxr_err_flags_t flags_q;
  cxr_err_flags_t flags_set;
  logic           rx_dis;
  logic           in_msg;
  logic           ev_word;
  logic           ev_start;
  logic           ev_end;
  logic           ev_lost;
  logic           rd_n_q;
  logic           rd_done;
  logic           err_read;
  logic           data_read;
  logic           err_now;
  logic           err_q;

  assign rx_dis   = I_RX_DISABLE | ctrl_q[`CXR_CTRL_DIS_BIT];
  assign in_msg   = (state_q == CXR_ACTIVE);
  assign ev_word  = I_LINE_EV.word_valid & ~rx_dis & in_msg;
  assign ev_start = I_LINE_EV.start_det & ~rx_dis;
  assign ev_end   = I_LINE_EV.end_det & ~rx_dis & in_msg;
  assign ev_lost  = I_LINE_EV.midbit_lost & ~rx_dis & in_msg &
                    ~I_LINE_EV.at_end_pos;
  assign rd_done  = I_REG_READ_N & ~rd_n_q;
  assign err_read  = rd_done & ~I_OUT_SEL;
  assign data_read = rd_done & I_OUT_SEL;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      rd_n_q <= 1'b1;
    end else begin
      rd_n_q <= I_REG_READ_N;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift stage and holding register occupancy.

  logic [9:0] hold_q;
  logic [9:0] shift_q;
  logic       hold_full_q;
  logic       shift_full_q;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      hold_q       <= 10'h000;
      shift_q      <= 10'h000;
      hold_full_q  <= 1'b0;
      shift_full_q <= 1'b0;
    end else begin
      if (data_read) begin
        hold_full_q  <= shift_full_q;
        shift_full_q <= 1'b0;
        if (shift_full_q) begin
          hold_q <= shift_q;
        end
      end
      if (ev_word && !err_now) begin
        if (!hold_full_q || (data_read && !shift_full_q)) begin
          hold_q      <= I_LINE_EV.word;
          hold_full_q <= 1'b1;
        end else if (!shift_full_q || data_read) begin
          shift_q      <= I_LINE_EV.word;
          shift_full_q <= 1'b1;
        end
      end
      // A fresh message discards a word left in the shift stage.
      if (ev_start) begin
        shift_full_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error detection.

  always_comb begin
    flags_set = '0;
    flags_set.overflow_flag_bit = ev_word & hold_full_q & shift_full_q &
                                  ~data_read;
    flags_set.parity_flag_bit   = ev_word &
      (^{I_LINE_EV.word, I_LINE_EV.sync_bit});
    flags_set.bad_ending_flag_bit = ev_end & ~I_LINE_EV.end_ok;
    flags_set.lost_transition_flag_bit = ev_lost;
    flags_set.early_start_flag_bit = ev_start & hold_full_q &
                                     ~data_read;
    flags_set.disabled_while_active_flag_bit = rx_dis &
      (state_q != CXR_IDLE);
  end

  assign err_now = |flags_set;

  // A new flag in the same cycle as a clear survives the clear.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      flags_q <= '0;
    end else if (err_read || ev_start) begin
      flags_q <= flags_set;
    end else begin
      flags_q <= flags_q | flags_set;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      err_q <= 1'b0;
    end else if (err_read || ev_start) begin
      err_q <= err_now;
    end else begin
      err_q <= err_q | err_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Message sequencing and the three delay timers.

  logic         rise_done;
  logic         first_done;
  logic         fall_done;
  logic         first_ok_q;
  logic         go_active;

  assign go_active = (state_q == CXR_STARTING) && rise_done && !err_now;

  cxr_cycle_timer #(.W(TW)) u_rise (
    .i_clk    (I_CORE_CLK),
    .i_rst    (I_SYS_RST),
    .i_start  (ev_start),
    .i_cancel (err_now),
    .i_count  (TW'(RISE_CYC)),
    .o_done   (rise_done)
  );

  cxr_cycle_timer #(.W(TW)) u_first (
    .i_clk    (I_CORE_CLK),
    .i_rst    (I_SYS_RST),
    .i_start  (go_active),
    .i_cancel (err_now || ev_start),
    .i_count  (TW'(FIRST_CYC)),
    .o_done   (first_done)
  );

  cxr_cycle_timer #(.W(TW)) u_fall (
    .i_clk    (I_CORE_CLK),
    .i_rst    (I_SYS_RST),
    .i_start  (ev_end && I_LINE_EV.end_ok),
    .i_cancel (err_now || ev_start),
    .i_count  (TW'(FALL_CYC)),
    .o_done   (fall_done)
  );

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      state_q <= CXR_IDLE;
    end else if (err_now) begin
      state_q <= CXR_IDLE;
    end else if (ev_start) begin
      state_q <= CXR_STARTING;
    end else begin
      case (state_q)
        CXR_STARTING: begin
          if (rise_done) begin
            state_q <= CXR_ACTIVE;
          end
        end
        CXR_ACTIVE: begin
          if (ev_end && I_LINE_EV.end_ok) begin
            state_q <= CXR_CLOSING;
          end
        end
        CXR_CLOSING: begin
          if (fall_done) begin
            state_q <= CXR_IDLE;
          end
        end
        default: begin
          state_q <= CXR_IDLE;
        end
      endcase
    end
  end

  // The first word of a message waits out its fixed delay; later ones don't.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      first_ok_q <= 1'b0;
    end else if (ev_start || err_now) begin
      first_ok_q <= 1'b0;
    end else if (first_done) begin
      first_ok_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs, all registered.

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      O_RX_ACTIVE <= 1'b0;
    end else begin
      O_RX_ACTIVE <= (go_active || state_q == CXR_ACTIVE ||
                      (state_q == CXR_CLOSING && !fall_done)) &&
                     !err_now;
    end
  end

  // Dropping for the read cycle leaves a visible gap between two words.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      O_DATA_AVAIL <= 1'b0;
    end else begin
      O_DATA_AVAIL <= hold_full_q && (first_ok_q || first_done) &&
                      !err_now && !err_q && !data_read;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      O_ERROR <= 1'b0;
    end else begin
      O_ERROR <= err_q;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      O_DATA <= 10'h000;
    end else if (I_OUT_SEL) begin
      O_DATA <= hold_q;
    end else begin
      O_DATA <= err_word(flags_q);
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      O_DATA_OE <= 10'h000;
    end else begin
      O_DATA_OE <= {10{I_OUT_EN}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read data, loaded while the access waits one cycle.

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      O_AVS_READDATA <= 32'h0000_0000;
    end else if (I_AVS_READ && wait_q) begin
      if (lane_hit(I_AVS_ADDRESS, `CXR_REG_CTRL)) begin
        O_AVS_READDATA <= ctrl_q;
      end else if (lane_hit(I_AVS_ADDRESS, `CXR_REG_STATUS)) begin
        O_AVS_READDATA <= {13'h0000, err_q, O_DATA_AVAIL, O_RX_ACTIVE,
                           6'h00, err_word(flags_q)};
      end else if (lane_hit(I_AVS_ADDRESS, `CXR_REG_WORD)) begin
        O_AVS_READDATA <= {22'h00_0000, hold_q};
      end else begin
        O_AVS_READDATA <= 32'h0000_0000;
      end
    end
  end

endmodule

// file: src/cxr_consts.svh
// Constants for the coax receiver output and error port.
`ifndef CXR_CONSTS_SVH
`define CXR_CONSTS_SVH

`define CXR_CLK_PERIOD_NS 4
`define CXR_NS2CYC(ns) (((ns) + `CXR_CLK_PERIOD_NS - 1) / `CXR_CLK_PERIOD_NS)
`define CXR_RX_DIV_DEF    13
`define CXR_RISE_HALF_T   7
`define CXR_RISE_EXTRA_NS 70
`define CXR_FIRST_T       92
`define CXR_FALL_HALF_T   23
`define CXR_FALL_EXTRA_NS 50

`define CXR_WORD_W        10
`define CXR_REG_CTRL      4'h0
`define CXR_REG_STATUS    4'h4
`define CXR_REG_WORD      4'h8
`define CXR_CTRL_RST      32'h0000_0000
`define CXR_CTRL_DIS_BIT  0
`define CXR_ST_ACTIVE_BIT 16
`define CXR_ST_AVAIL_BIT  17
`define CXR_ST_ERROR_BIT  18
`endif

// file: src/cxr_pkg.sv
// Types shared by the coax receiver output and error port.
package cxr_pkg;

  // Events from the demodulator and shift stage, all one-cycle pulses.
  typedef struct packed {
    logic       word_valid;
    logic [9:0] word;
    logic       sync_bit;
    logic       start_det;
    logic       end_det;
    logic       end_ok;
    logic       midbit_lost;
    logic       at_end_pos;
  } cxr_line_ev_t;

  // Sticky error flags, most significant first, as they sit on bits 8..2.
  typedef struct packed {
    logic disabled_while_active_flag_bit;
    logic early_start_flag_bit;
    logic lost_transition_flag_bit;
    logic bad_ending_flag_bit;
    logic transmit_check_flag_bit;
    logic parity_flag_bit;
    logic overflow_flag_bit;
  } cxr_err_flags_t;

  typedef enum logic [1:0] {
    CXR_IDLE,
    CXR_STARTING,
    CXR_ACTIVE,
    CXR_CLOSING
  } cxr_state_t;

endpackage

// file: src/cxr_cycle_timer.sv
// One-shot cycle timer that pulses once a loaded count has elapsed.
module cxr_cycle_timer #(
  parameter int W = 16
) (
  input  wire logic         i_clk,    // Core clock.
  input  wire logic         i_rst,    // Synchronous reset, active high.
  input  wire logic         i_start,  // Load the count and run.
  input  wire logic         i_cancel, // Stop without a pulse.
  input  wire logic [W-1:0] i_count,  // Cycles from start to done.
  output logic              o_done    // One-cycle pulse on expiry.
);

  logic [W-1:0] cnt_q;
  logic         run_q;

  always_ff @(posedge i_clk) begin
    if (i_rst || i_cancel) begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      o_done <= 1'b0;
    end else if (i_start) begin
      cnt_q  <= i_count - W'(1);
      run_q  <= 1'b1;
      o_done <= 1'b0;
    end else if (run_q && cnt_q <= W'(1)) begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      o_done <= 1'b1;
    end else begin
      cnt_q  <= run_q ? cnt_q - W'(1) : cnt_q;
      o_done <= 1'b0;
    end
  end

endmodule

// file: sim/cxr_output_port_asserts.sv
// Concurrent checks on the ports of the coax receiver output port.
module cxr_output_port_asserts
  import cxr_pkg::*;
#(
  parameter int RX_DIV = 2
) (
  input wire logic         I_CORE_CLK,   // Core clock.
  input wire logic         I_SYS_RST,    // Synchronous reset.
  input wire cxr_line_ev_t I_LINE_EV,    // Line events.
  input wire logic         I_OUT_SEL,    // Output select.
  input wire logic         I_OUT_EN,     // Output enable.
  input wire logic         I_REG_READ_N, // Read strobe.
  input wire logic [9:0]   O_DATA,       // Data bus.
  input wire logic [9:0]   O_DATA_OE,    // Bus enables.
  input wire logic         O_RX_ACTIVE,  // Message active.
  input wire logic         O_DATA_AVAIL, // Word ready.
  input wire logic         O_ERROR       // Error.
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RISE_LO = (7 * RX_DIV) / 2 + 17;
  localparam int RISE_HI = RISE_LO + 4;
  localparam int FALL_LO = (23 * RX_DIV) / 2 + 12;
  localparam int FALL_HI = FALL_LO + 4;
  localparam int FST_LO  = 92 * RX_DIV - 3;
  localparam int FST_HI  = 92 * RX_DIV + 3;

  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  //////////////////////////////////////////////////////////////////////////
  // The first word is timed from the active edge, later words are not.
  logic [15:0] since_q;
  logic        first_q;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST || !O_RX_ACTIVE) begin
      since_q <= 16'h0000;
      first_q <= 1'b1;
    end else begin
      since_q <= since_q + 16'h0001;
      if (O_DATA_AVAIL) begin
        first_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  sequence s_start;
    I_LINE_EV.start_det && !O_RX_ACTIVE;
  endsequence
  sequence s_good_end;
    I_LINE_EV.end_det && I_LINE_EV.end_ok && O_RX_ACTIVE;
  endsequence
  sequence s_err_sel;
    !I_OUT_SEL && !$past(I_OUT_SEL);
  endsequence

  property p_oe_follow;
    !$past(I_SYS_RST) && $stable(I_OUT_EN) |-> O_DATA_OE == {10{I_OUT_EN}};
  endproperty
  a_oe_follow: assert property (p_oe_follow)
    else $error("bus enables do not follow output enable");
  property p_zero_pos;
    s_err_sel |-> O_DATA[9] == 1'b0 && O_DATA[1:0] == 2'b00;
  endproperty
  a_zero_pos: assert property (p_zero_pos)
    else $error("unflagged positions of the error word not zero");
  property p_check_or;
    s_err_sel ##0 $stable(O_DATA)
      |-> O_DATA[4] == (O_DATA[3] | O_DATA[5] | O_DATA[6]);
  endproperty
  a_check_or: assert property (p_check_or)
    else $error("transmit check flag is not the OR of its sources");
  property p_err_quiet;
    O_ERROR |-> !O_RX_ACTIVE && !O_DATA_AVAIL;
  endproperty
  a_err_quiet: assert property (p_err_quiet)
    else $error("active or available high while error is set");
  property p_rise;
    s_start |-> ##[RISE_LO:RISE_HI] O_RX_ACTIVE;
  endproperty
  a_rise: assert property (p_rise)
    else $error("active did not rise in time after a start");
  property p_first;
    $rose(O_DATA_AVAIL) && first_q |-> since_q >= FST_LO && since_q <= FST_HI;
  endproperty
  a_first: assert property (p_first)
    else $error("first data available at the wrong time");
  property p_fall;
    s_good_end |-> ##[FALL_LO:FALL_HI] !O_RX_ACTIVE;
  endproperty
  a_fall: assert property (p_fall)
    else $error("active did not fall in time after a valid ending");
  property p_clear;
    $rose(I_REG_READ_N) && !I_OUT_SEL |-> ##[1:3] !O_ERROR;
  endproperty
  a_clear: assert property (p_clear)
    else $error("error not cleared by an error read");
endmodule

bind cxr_output_port cxr_output_port_asserts #(.RX_DIV(RX_DIV)) u_chk (
  .I_CORE_CLK  (I_CORE_CLK),
  .I_SYS_RST   (I_SYS_RST),
  .I_LINE_EV   (I_LINE_EV),
  .I_OUT_SEL   (I_OUT_SEL),
  .I_OUT_EN    (I_OUT_EN),
  .I_REG_READ_N(I_REG_READ_N),
  .O_DATA      (O_DATA),
  .O_DATA_OE   (O_DATA_OE),
  .O_RX_ACTIVE (O_RX_ACTIVE),
  .O_DATA_AVAIL(O_DATA_AVAIL),
  .O_ERROR     (O_ERROR)
);

// file: sim/cxr_host_model.sv
// Host model that sets the output select and makes read strobes.
module cxr_host_model (
  input  wire logic i_clk,     // Core clock.
  input  wire logic i_rst,     // Synchronous reset.
  input  wire logic i_sel,     // Wanted output select.
  input  wire logic i_go,      // Start one read strobe.
  output logic      o_out_sel, // Output select to the port.
  output logic      o_read_n,  // Read strobe, active low.
  output logic      o_busy     // Strobe in progress.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;
  assign o_busy = cnt_q != 2'h0;
  // Select is frozen during a strobe so it is set up and held around it.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q    <= 2'h0;
      o_read_n <= 1'b1;
      o_out_sel <= 1'b0;
    end else begin
      if (!o_busy) begin
        o_out_sel <= i_sel;
      end
      if (i_go && !o_busy) begin
        cnt_q <= 2'h3;
      end else if (o_busy) begin
        cnt_q <= cnt_q - 2'h1;
      end
      o_read_n <= !(cnt_q == 2'h3 || cnt_q == 2'h2);
    end
  end
endmodule

// file: sim/cxr_output_port_tb.sv
// Self-checking bench for the coax receiver output and error port.
`define CHK(nm, e, s) begin \
  checked++; \
  if ((s) !== (e)) begin \
    n_errors++; \
    $display("Error %s exp %h got %h", nm, e, s); \
  end \
end

module cxr_output_port_tb import cxr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RXD   = 2;
  localparam int RISE  = (7 * RXD) / 2 + 18;
  localparam int FIRST = 92 * RXD;
  localparam int FALL  = (23 * RXD) / 2 + 13;
  logic         clk, rst, dis, hsel, go, oe, rd, wr, read_n, osel, busy;
  logic         act, avail, err, wreq;
  logic [3:0]   addr;
  logic [31:0]  wd, rdata, q;
  logic [9:0]   data, doe;
  cxr_line_ev_t ev;
  int           n_errors, checked, n;
  logic [9:0]   exp_t [7] = '{10'h018, 10'h030, 10'h050, 10'h100,
                              10'h100, 10'h080, 10'h004};

  cxr_output_port #(.RX_DIV(RXD)) u_dut (
    .I_CORE_CLK       (clk),
    .I_SYS_RST        (rst),
    .I_LINE_EV        (ev),
    .I_RX_DISABLE     (dis),
    .I_OUT_SEL        (osel),
    .I_OUT_EN         (oe),
    .I_REG_READ_N     (read_n),
    .O_DATA           (data),
    .O_DATA_OE        (doe),
    .O_RX_ACTIVE      (act),
    .O_DATA_AVAIL     (avail),
    .O_ERROR          (err),
    .I_AVS_ADDRESS    (addr),
    .I_AVS_READ       (rd),
    .I_AVS_WRITE      (wr),
    .I_AVS_WRITEDATA  (wd),
    .I_AVS_BYTEENABLE (4'hf),
    .O_AVS_READDATA   (rdata),
    .O_AVS_WAITREQUEST(wreq)
  );
  cxr_host_model u_host (
    .i_clk    (clk),
    .i_rst    (rst),
    .i_sel    (hsel),
    .i_go     (go),
    .o_out_sel(osel),
    .o_read_n (read_n),
    .o_busy   (busy)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // The idle edge after release keeps two requests from meeting in one step.
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    addr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 20);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 20) n_errors++;
    @(posedge clk);
  endtask

  task automatic pulse(input cxr_line_ev_t e);
    ev <= e;
    @(posedge clk);
    ev <= '0;
    @(posedge clk);
  endtask

  task automatic word(input logic [9:0] w);
    cxr_line_ev_t e;
    e = '0;
    e.word_valid = 1'b1;
    e.word = w;
    e.sync_bit = ^w;
    pulse(e);
  endtask

  task automatic start;
    cxr_line_ev_t e;
    e = '0;
    e.start_det = 1'b1;
    pulse(e);
  endtask

  task automatic wsig(input int k, input logic v, output int c);
    c = 0;
    while (c < 600 && (k == 0 ? act : k == 1 ? avail : err) !== v) begin
      @(posedge clk);
      c++;
    end
  endtask

  task automatic hread(input logic s);
    hsel <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    `CHK("act", 1'b0, act);
    `CHK("err", 1'b0, err);
    `CHK("oe", 10'h000, doe);
    bus(1'b0, 4'hc, 32'h0, q);
    `CHK("unmapped", 32'h0, q);
    bus(1'b1, 4'h0, 32'h1, q);
    bus(1'b0, 4'h0, 32'h0, q);
    `CHK("ctrl", 1'b1, q[0]);
    bus(1'b1, 4'h0, 32'h0, q);
    $display("t_reset done");
  endtask

  task automatic t_msg;
    cxr_line_ev_t e;
    hsel <= 1'b1;
    start;
    wsig(0, 1'b1, n);
    `CHK("rise", 1'b1, n >= RISE - 3 && n <= RISE + 3);
    word(10'h2a5);
    wsig(1, 1'b1, n);
    `CHK("first", 1'b1, n >= FIRST - 8 && n <= FIRST + 2);
    bus(1'b0, 4'h4, 32'h0, q);
    `CHK("stat_on", 3'b011, q[18:16]);
    bus(1'b0, 4'h8, 32'h0, q);
    `CHK("word", 32'h0000_02a5, q);
    oe <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("data", 10'h2a5, data);
    `CHK("drive", 10'h3ff, doe);
    oe <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("float", 10'h000, doe);
    hread(1'b1);
    // A missing transition in the ending slot is normal and must not flag.
    e = '0;
    e.midbit_lost = 1'b1;
    e.at_end_pos = 1'b1;
    pulse(e);
    e = '0;
    e.end_det = 1'b1;
    e.end_ok = 1'b1;
    pulse(e);
    wsig(0, 1'b0, n);
    `CHK("fall", 1'b1, n >= FALL - 3 && n <= FALL + 3);
    `CHK("clean", 1'b0, err);
    $display("t_msg done");
  endtask

  task automatic t_flags;
    cxr_line_ev_t e;
    oe <= 1'b1;
    for (int k = 0; k < 7; k++) begin
      hsel <= 1'b0;
      start;
      wsig(0, 1'b1, n);
      if (k >= 5) begin
        word(10'h0f0);
        wsig(1, 1'b1, n);
      end
      e = '0;
      case (k)
        0: begin
          e.word_valid = 1'b1;
          e.word = 10'h001;
        end
        1: e.end_det = 1'b1;
        2: e.midbit_lost = 1'b1;
        3: dis <= 1'b1;
        4: bus(1'b1, 4'h0, 32'h1, q);
        5: e.start_det = 1'b1;
        6: begin
          word(10'h0f1);
          e.word_valid = 1'b1;
          e.word = 10'h0f2;
        end
        default: e = '0;
      endcase
      if (k == 6) e.sync_bit = ^e.word;
      pulse(e);
      wsig(2, 1'b1, n);
      dis <= 1'b0;
      if (k == 4) bus(1'b1, 4'h0, 32'h0, q);
      `CHK("act", 1'b0, act);
      repeat (3) @(posedge clk);
      `CHK("code", exp_t[k], data);
      bus(1'b0, 4'h4, 32'h0, q);
      `CHK("stat", {3'b100, exp_t[k]}, {q[18:16], q[9:0]});
      hread(1'b0);
      `CHK("clear", 1'b0, err);
      // The unread word would make the next start an early-start error.
      if (k == 5) begin
        hread(1'b1);
        `CHK("held", 10'h0f0, data);
      end
    end
    $display("t_flags done");
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    ev = '0;
    {dis, hsel, go, oe, rd, wr} = 6'h00;
    addr = 4'h0;
    wd = 32'h0;
    n_errors = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset;
    t_msg;
    t_flags;
    summarize;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize;
  end
endmodule
